// ### pkg/chain_adc_pkg.sv
package chain_adc_pkg;
  // ----------------------------------------------------------------
  // Word and chain geometry
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 16;
  localparam int TAG_EDGE = 17;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RECOVERY_US = 1000;
  localparam int RECOVERY_CYCLES = (RECOVERY_US * 1000) / CLK_PERIOD_NS;
  localparam int SHIFT_DIV_HALF = 4;
  localparam int GUARD_CYCLES = 2;

  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CONVERT = 3'b001,
    ST_WAIT_DONE = 3'b010,
    ST_SHIFT = 3'b011,
    ST_FINISH = 3'b100
  } host_state_type;
endpackage : chain_adc_pkg

// ### pkg/chain_adc_if.sv
`timescale 1ns/10ps
interface chain_adc_if;
  logic shift_clock;
  logic serial_result_out;
  logic chain_in;
  logic analog_sleep;
  logic reference_sleep;
  logic convert_n;
  logic busy;
  logic clock_source_select;

  modport converter (
    input shift_clock, chain_in, analog_sleep, reference_sleep, convert_n,
    input clock_source_select,
    output serial_result_out, busy
  );
  modport controller (
    output shift_clock, analog_sleep, reference_sleep, convert_n, clock_source_select,
    output chain_in,
    input serial_result_out, busy
  );
endinterface : chain_adc_if

// ### rtl/sync_two_ff.sv
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : sync_two_ff

// ### rtl/chain_adc_device.sv
`timescale 1ns/10ps
// Overview of operation
// RL1 - Chain input appears at seventeenth shift clock; code: nineteenth, after two sync clocks
// RL2 - Forwarding same for internal or external clock
// RL3 - Output feeds next chain input, last feeds host
// RL4 - Host receives last converter's serial output
// RL5 - Shifting synchronous to external shift clock
// RL6 - Cascades use one common external clock
// RL7 - Seventeenth clock moves upstream MSB downstream; code: nineteenth, after two sync clocks
// RL8 - Host reads only during sampling period
// RL9 - Sampling interval covers whole chain readout
// RL10 - Full sleep keeps unshifted previous result
// RL11 - Analog sleep keeps reference, result readable
// RL12 - Result held and readable during analog sleep
// RL13 - Conversion during analog sleep gives invalid data
// RL14 - Reference sleep disables only internal reference
// RL15 - Digital logic always operational
// RL16 - Host waits recovery after releasing sleep
// RL17 - Hold reference sleep with external reference
// RL18 - Digital inputs low until supply settles; host holds convert_n and clock_source_select high
// RL19 - One chain bit per clock, forwarded in order
// RL20 - MSB valid first falling, second rising edge; code: third falling, fourth rising edge
// RL21 - No shift clock during late conversion
// RL22 - Host gives sixteen clocks per converter; code gives 16*N+2, two sync clocks first
// RL23 - Output is sixteen-bit register filled from chain
module chain_adc_device #(
  parameter int BITS = chain_adc_pkg::RESULT_BITS,
  parameter int CONV_CYCLES = 8
) (
  // Link side, clocked by shift clock
  chain_adc_if.converter link,
  // Converter core side
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [BITS-1:0] i_sample,
  // Status
  output logic o_result_valid,
  output logic o_analog_on,
  output logic o_reference_on
);
  initial begin
    if (BITS != 16) $error("chain_adc_device: BITS must be 16");
    if (CONV_CYCLES < 2) $error("chain_adc_device: CONV_CYCLES too small");
  end

  // ----------------------------------------------------------------
  // Core domain: conversion and power state
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic conv_n_s, asleep_s, rsleep_s, conv_n_d_reg;
  logic [BITS-1:0] result_reg;
  logic result_bad_reg;
  logic [7:0] conv_cnt_reg;
  logic busy_n_reg;
  logic load_tgl_reg;
  logic conv_start;

  sync_two_ff #(.WIDTH(3)) u_pin_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async({link.convert_n, link.analog_sleep, link.reference_sleep}),
    .o_sync(pins_sync)
  );
  assign conv_n_s = pins_sync[2];
  assign asleep_s = pins_sync[1];
  assign rsleep_s = pins_sync[0];
  assign conv_start = conv_n_d_reg && !conv_n_s;

  // Conversion timer; runs in any sleep state, analog sleep only marks the result bad  see RL15
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_n_d_reg <= 1'b1;
      conv_cnt_reg <= 8'h00;
      busy_n_reg <= 1'b1;
      result_reg <= chain_adc_pkg::RESULT_RESET;
      result_bad_reg <= 1'b0;
      load_tgl_reg <= 1'b0;
    end else begin
      conv_n_d_reg <= conv_n_s;
      if (conv_start && busy_n_reg) begin
        busy_n_reg <= 1'b0;
        conv_cnt_reg <= 8'(CONV_CYCLES);
        result_bad_reg <= asleep_s; // Sleeping front end yields junk  see RL13
      end else if (!busy_n_reg) begin
        if (conv_cnt_reg == 8'h01) begin
          busy_n_reg <= 1'b1;
          result_reg <= result_bad_reg ? ~i_sample : i_sample;
          load_tgl_reg <= ~load_tgl_reg; // Event to link domain
        end
        conv_cnt_reg <= conv_cnt_reg - 8'h01;
      end
    end
  end

  // Power state flags, from flops  see RL10 see RL11 see RL14
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_analog_on <= 1'b0;
      o_reference_on <= 1'b0;
      o_result_valid <= 1'b0;
    end else begin
      o_analog_on <= !asleep_s;
      o_reference_on <= !rsleep_s; // Buffer stays up either way
      o_result_valid <= busy_n_reg && !result_bad_reg;
    end
  end

  // Busy is a level; the host synchronises it
  assign link.busy = busy_n_reg;

  // ----------------------------------------------------------------
  // Link domain: output shifter on the shift clock
  // ----------------------------------------------------------------
  // Load toggle crosses by two flops; the link clock is gated, so a new
  // result is taken on the third edge of the next read, after two sync edges.
  logic [BITS-1:0] shift_reg;
  logic [1:0] tgl_sync_reg;
  logic tgl_seen_reg;
  logic link_rst_n;

  assign link_rst_n = i_resetn;

  always_ff @(posedge link.shift_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tgl_sync_reg <= 2'b00;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[0], load_tgl_reg};
    end
  end

  // Result stays held in sleep until shifted out  see RL10 see RL12
  // Vacated LSB refills from chain input each clock except the load edge  see RL23 see RL19
  // Same path for any clock source, cascades shift in step  see RL2 see RL5
  always_ff @(posedge link.shift_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_reg <= chain_adc_pkg::RESULT_RESET;
      tgl_seen_reg <= 1'b0;
    end else if (tgl_sync_reg[1] != tgl_seen_reg) begin
      shift_reg <= result_reg; // Stable: result changed >2 clocks earlier
      tgl_seen_reg <= tgl_sync_reg[1];
    end else begin
      shift_reg <= {shift_reg[BITS-2:0], link.chain_in};
    end
  end

  // MSB presented until the next rising edge shifts it along  see RL20
  // After 16 shifts chain bit leads at clock 19  see RL1 see RL7 see RL3
  assign link.serial_result_out = shift_reg[BITS-1];
endmodule : chain_adc_device

// ### rtl/chain_adc_host.sv
`timescale 1ns/10ps
module chain_adc_host #(
  parameter int CHAIN_LEN = 2,
  parameter int RECOVERY = chain_adc_pkg::RECOVERY_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // User command side
  input wire logic i_start,
  input wire logic i_sleep,
  input wire logic i_ext_reference,
  // Results
  output logic [15:0] o_word,
  output logic o_word_valid,
  output logic o_ready,
  // Link
  chain_adc_if.controller link
);
  initial begin
    if (CHAIN_LEN < 1 || CHAIN_LEN > 64) $error("chain_adc_host: bad CHAIN_LEN");
  end

  chain_adc_pkg::host_state_type state_reg;
  logic [1:0] busy_sync;
  logic [11:0] bit_cnt_reg;
  logic [3:0] div_reg;
  logic sclk_reg;
  logic [15:0] rx_reg;
  logic [31:0] rec_cnt_reg;
  logic conv_n_reg;
  logic [3:0] guard_reg;
  logic busy_s;

  sync_two_ff #(.WIDTH(1)) u_busy_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(link.busy),
    .o_sync(busy_sync[0])
  );
  assign busy_sync[1] = 1'b0;
  assign busy_s = busy_sync[0];

  // Pins idle low, convert strobe released high; external clock only
  // see RL6 see RL17 see RL18
  assign link.clock_source_select = 1'b1;
  assign link.shift_clock = sclk_reg;
  assign link.convert_n = conv_n_reg;
  assign link.analog_sleep = i_sleep;
  assign link.reference_sleep = i_sleep || i_ext_reference;
  assign link.chain_in = 1'b0; // Host end of chain idle

  // Recovery wait after leaving sleep  see RL16
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rec_cnt_reg <= 32'h0000_0000;
    end else if (i_sleep) begin
      rec_cnt_reg <= 32'(RECOVERY);
    end else if (rec_cnt_reg != 32'h0000_0000) begin
      rec_cnt_reg <= rec_cnt_reg - 32'h0000_0001;
    end
  end

  // Sequencer: convert, wait for busy release, then clock the chain
  // Clock stays still during conversion  see RL8 see RL21
  // Two sync edges let the converters take the new result, then 16*N data
  // clocks; the next start is allowed only after that  see RL9 see RL22
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= chain_adc_pkg::ST_IDLE;
      conv_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      div_reg <= 4'h0;
      bit_cnt_reg <= 12'h000;
      rx_reg <= 16'h0000;
      o_word <= 16'h0000;
      o_word_valid <= 1'b0;
      o_ready <= 1'b0;
      guard_reg <= 4'h0;
    end else begin
      o_word_valid <= 1'b0;
      o_ready <= (state_reg == chain_adc_pkg::ST_IDLE) && !i_sleep &&
                 (rec_cnt_reg == 32'h0000_0000);
      case (state_reg)
        chain_adc_pkg::ST_IDLE: begin
          if (i_start && o_ready) begin
            conv_n_reg <= 1'b0;
            guard_reg <= 4'(chain_adc_pkg::SHIFT_DIV_HALF);
            state_reg <= chain_adc_pkg::ST_CONVERT;
          end
        end
        chain_adc_pkg::ST_CONVERT: begin
          guard_reg <= guard_reg - 4'h1;
          if (!busy_s) begin
            conv_n_reg <= 1'b1;
            state_reg <= chain_adc_pkg::ST_WAIT_DONE;
          end
        end
        chain_adc_pkg::ST_WAIT_DONE: begin
          if (busy_s) begin
            bit_cnt_reg <= 12'(16 * CHAIN_LEN + 2);
            div_reg <= 4'h0;
            state_reg <= chain_adc_pkg::ST_SHIFT;
          end
        end
        chain_adc_pkg::ST_SHIFT: begin
          div_reg <= div_reg + 4'h1;
          if (div_reg == 4'(chain_adc_pkg::SHIFT_DIV_HALF - 1)) begin
            div_reg <= 4'h0;
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              // Falling edge: sample bit presented since the rising edge
              bit_cnt_reg <= bit_cnt_reg - 12'h001;
              if (bit_cnt_reg == 12'h001) begin
                state_reg <= chain_adc_pkg::ST_FINISH;
              end
            end
          end
        end
        chain_adc_pkg::ST_FINISH: begin
          state_reg <= chain_adc_pkg::ST_IDLE;
        end
        default: state_reg <= chain_adc_pkg::ST_IDLE;
      endcase
      // Receive from last converter, nearest word first  see RL4
      if (state_reg == chain_adc_pkg::ST_SHIFT && sclk_reg &&
          div_reg == 4'(chain_adc_pkg::SHIFT_DIV_HALF - 1) &&
          bit_cnt_reg <= 12'(16 * CHAIN_LEN)) begin
        rx_reg <= {rx_reg[14:0], link.serial_result_out};
        if (bit_cnt_reg[3:0] == 4'h1) begin
          o_word <= {rx_reg[14:0], link.serial_result_out};
          o_word_valid <= 1'b1;
        end
      end
    end
  end
endmodule : chain_adc_host

// ### sim/chain_adc_link_assertions.sv
`timescale 1ns/10ps
module chain_adc_link_assertions (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Link signals
  input wire logic shift_clock,
  input wire logic serial_result_out,
  input wire logic analog_sleep,
  input wire logic reference_sleep,
  input wire logic convert_n,
  input wire logic busy,
  input wire logic clock_source_select
);
  // ----------------------------------------------------------------
  // Frame edge counter
  // ----------------------------------------------------------------
  // Two converters: sixteen edges each plus two result sync edges
  localparam int FRAME_EDGES = 2 * 16 + 2;
  logic shift_q_reg;
  logic conv_q_reg;
  logic [7:0] edge_cnt_reg;
  logic [7:0] edge_cnt_next;
  wire logic shift_rise = shift_clock & ~shift_q_reg;
  wire logic conv_fall = ~convert_n & conv_q_reg;
  assign edge_cnt_next = conv_fall ? 8'h00 : (shift_rise ? edge_cnt_reg + 8'h01 : edge_cnt_reg);

  // Count restarts at each conversion so short frames are caught
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_q_reg <= 1'b0;
      conv_q_reg <= 1'b1;
      edge_cnt_reg <= 8'h00;
    end else begin
      shift_q_reg <= shift_clock;
      conv_q_reg <= convert_n;
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  clock_ext_a: assert property (clock_source_select)
    else $error("clock source not external");
  shift_busy_a: assert property ($rose(shift_clock) |-> busy)
    else $error("shift clock during conversion");
  shift_half_a: assert property ($rose(shift_clock) |-> shift_clock [*4] ##1 !shift_clock)
    else $error("shift clock high phase wrong");
  data_edge_a: assert property ($changed(serial_result_out) |-> $rose(shift_clock))
    else $error("serial data moved off a rising shift edge");
  frame_count_a: assert property (conv_fall |-> edge_cnt_reg == 0 || edge_cnt_reg == FRAME_EDGES)
    else $error("frame did not carry all shift edges");
  busy_fall_a: assert property ($fell(convert_n) |-> ##[1:8] !busy)
    else $error("busy did not fall after convert");
  busy_rise_a: assert property ($fell(busy) |-> ##[1:60] busy)
    else $error("conversion did not complete");
  conv_pulse_a: assert property ($fell(convert_n) |-> ##[1:8] convert_n)
    else $error("convert strobe too long");
  sleep_hold_a: assert property (analog_sleep |-> convert_n)
    else $error("conversion started in analog sleep");

  cover property (edge_cnt_reg == FRAME_EDGES);
  cover property (analog_sleep && reference_sleep);
  cover property (reference_sleep && !analog_sleep);
endmodule : chain_adc_link_assertions

// ### sim/adc_daisy_chain_readout_powerdown_tb_top.sv
`timescale 1ns/10ps
module adc_daisy_chain_readout_powerdown_tb_top;
  // ----------------------------------------------------------------
  // Signals and chain wiring
  // ----------------------------------------------------------------
  logic i_clk;
  logic i_resetn;
  logic i_start;
  logic i_sleep;
  logic i_ext_reference;
  logic [15:0] sample_a;
  logic [15:0] sample_b;
  logic [15:0] o_word;
  logic o_word_valid;
  logic o_ready;
  logic [1:0] valid_dev;
  logic [1:0] analog_on;
  logic [1:0] ref_on;
  int fails;
  int tests_run;
  chain_adc_if if_h ();
  chain_adc_if if_a ();
  chain_adc_if if_b ();

  // Host controls fan out to both; far converter A feeds near converter B
  assign if_a.shift_clock = if_h.shift_clock;
  assign if_a.analog_sleep = if_h.analog_sleep;
  assign if_a.reference_sleep = if_h.reference_sleep;
  assign if_a.convert_n = if_h.convert_n;
  assign if_a.clock_source_select = if_h.clock_source_select;
  assign if_a.chain_in = if_h.chain_in;
  assign if_b.shift_clock = if_h.shift_clock;
  assign if_b.analog_sleep = if_h.analog_sleep;
  assign if_b.reference_sleep = if_h.reference_sleep;
  assign if_b.convert_n = if_h.convert_n;
  assign if_b.clock_source_select = if_h.clock_source_select;
  assign if_b.chain_in = if_a.serial_result_out;
  assign if_h.serial_result_out = if_b.serial_result_out;
  // Host sees idle only when both converters are idle
  assign if_h.busy = if_a.busy & if_b.busy;

  chain_adc_host #(.CHAIN_LEN(2), .RECOVERY(16)) chain_adc_host_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_start(i_start), .i_sleep(i_sleep),
    .i_ext_reference(i_ext_reference), .o_word(o_word), .o_word_valid(o_word_valid),
    .o_ready(o_ready), .link(if_h.controller));
  chain_adc_device #(.CONV_CYCLES(8)) chain_adc_device_inst_a (.link(if_a.converter),
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sample(sample_a), .o_result_valid(valid_dev[0]),
    .o_analog_on(analog_on[0]), .o_reference_on(ref_on[0]));
  chain_adc_device #(.CONV_CYCLES(8)) chain_adc_device_inst_b (.link(if_b.converter),
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sample(sample_b), .o_result_valid(valid_dev[1]),
    .o_analog_on(analog_on[1]), .o_reference_on(ref_on[1]));
  chain_adc_link_assertions chain_adc_link_assertions_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .shift_clock(if_h.shift_clock),
    .serial_result_out(if_h.serial_result_out), .analog_sleep(if_h.analog_sleep),
    .reference_sleep(if_h.reference_sleep), .convert_n(if_h.convert_n), .busy(if_h.busy),
    .clock_source_select(if_h.clock_source_select));

  // 125 MHz system clock; the shift clock is divided down by the host
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Compare and report tasks
  // ----------------------------------------------------------------
  task chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Bounded wait; a host stuck in recovery or sleep ends the run
  task wait_ready(output int n);
    n = 0;
    while (o_ready !== 1'b1 && n < 500) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 500) begin
      chk_bit("o_ready", 1'b1, o_ready);
      report_and_stop();
    end
  endtask : wait_ready

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task run_read(input string name, input logic [15:0] a_val, input logic [15:0] b_val);
    logic [15:0] got [0:1];
    int k;
    int n;
    sample_a = a_val;
    sample_b = b_val;
    wait_ready(n);
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    k = 0;
    n = 0;
    while (k < 2 && n < 3000) begin
      @(negedge i_clk);
      n++;
      if (o_word_valid === 1'b1) begin
        got[k] = o_word;
        k++;
      end
    end
    if (k < 2) begin
      chk_bit("word count", 1'b1, 1'b0);
      report_and_stop();
    end
    chk_word("near word", b_val, got[0]);
    chk_word("far word", a_val, got[1]);
    chk_word("result valid", 16'h0003, {14'h0000, valid_dev});
    $display("test %s done", name);
  endtask : run_read

  // Full sleep, refused start, recovery, then reference-only sleep and wake
  task run_sleep;
    int n;
    i_sleep = 1'b1;
    i_ext_reference = 1'b1;
    n = 0;
    while (analog_on !== 2'b00 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    chk_word("full sleep", 16'h0000, {12'h000, analog_on, ref_on});
    chk_bit("ready in sleep", 1'b0, o_ready);
    i_start = 1'b1;
    repeat (8) @(negedge i_clk);
    i_start = 1'b0;
    chk_bit("convert in sleep", 1'b1, if_h.convert_n);
    i_sleep = 1'b0;
    wait_ready(n);
    chk_bit("recovery wait", 1'b1, n >= 16);
    chk_word("reference sleep", 16'h000C, {12'h000, analog_on, ref_on});
    chk_bit("reference pin", 1'b1, if_h.reference_sleep);
    i_ext_reference = 1'b0;
    n = 0;
    while (ref_on !== 2'b11 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    chk_word("awake", 16'h000F, {12'h000, analog_on, ref_on});
    $display("test sleep done");
  endtask : run_sleep

  initial begin
    i_resetn = 1'b0;
    i_start = 1'b0;
    i_sleep = 1'b0;
    i_ext_reference = 1'b0;
    sample_a = 16'h0000;
    sample_b = 16'h0000;
    fails = 0;
    tests_run = 0;
    repeat (16) @(negedge i_clk);
    i_resetn = 1'b1;
    run_read("plain", 16'hA5C3, 16'h3C5A);
    run_read("back to back", 16'hFFFF, 16'h0001);
    run_read("top bit", 16'h0000, 16'h8000);
    run_sleep();
    run_read("after wake", 16'h1234, 16'hFEDC);
    report_and_stop();
  end
endmodule : adc_daisy_chain_readout_powerdown_tb_top
